// File: core/pirl_top.sv
`timescale 1ns/1ps
`include "pirl_defs.svh"

// Contract
// - Nineteen prioritised sources, each routable to a location.
// - Five-bit codes: audio high 0, SPI high 1, timer0 2, serial 3-8.
// - Parallel 9, timer1 A, audio low C, PWM D, timer2 11, SPI low 12.
// - Code 1F routes a constant high so software can force a location.
// - Extended register is a core system register, also driven on the ext_interrupt_latch_mask port, reset to zero.
// - Register holds latch status, mask bits and mask pointer copies.
// - Latch bits take their source from the select codes, defaults at reset.
// - Bits 0-4 latch locations 6-10, bit 5 reserved, 6-7 latch 12-13.
// - Serial request raised two cycles after a word's last bit.
// - Parallel request raised when a DMA block transfer completes.
// - Core transfers request while tx not full or rx not empty.
// - Bit 6 default is the low-priority audio request, not the high one.
// - Bits 8-9 latch locations 17-18, default timer2 and low SPI.
// - Bits 10-19 mask bits, one unmasks, bit 15 reserved.
// - Bits 20-29 mask pointer copies; 25, 30, 31 reserved.

module pirl_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire pirl_pkg::pirl_src_t src,
  input wire logic [`PIRL_NSER-1:0] ser_word_done,
  input wire pirl_pkg::pirl_pp_t pp,
  input wire logic sel_wr,
  input wire logic [3:0] sel_idx,
  input wire pirl_pkg::pirl_code_t sel_code,
  input wire pirl_pkg::pirl_sreg_t sreg,
  input wire logic [`PIRL_NLOC-1:0] ack,
  input wire logic svc_enter,
  input wire logic svc_exit,
  output logic [31:0] sreg_rdata,
  output logic [31:0] ext_interrupt_latch_mask,
  output logic [`PIRL_NLOC-1:0] irq_pend
);
  import pirl_pkg::*;

  localparam int NLOC = `PIRL_NLOC;
  localparam logic [NLOC-1:0] LOC_VALID = `PIRL_LOC_VALID;

  logic [`PIRL_NSER-1:0] ser_irq;
  logic parallel_port_irq;
  logic [`PIRL_NSRC-1:0] reqs;
  pirl_code_t sel [NLOC];
  logic [NLOC-1:0] hit;
  logic [NLOC-1:0] lat;
  logic [NLOC-1:0] next_lat;
  logic [NLOC-1:0] msk;
  logic [NLOC-1:0] mask_pointer_bits;

  // Default routing of each latch position.
  function automatic pirl_code_t pirl_default(input int idx);
    case (idx)
      0: return `PIRL_C_SER0;
      1: return `PIRL_C_SER2;
      2: return `PIRL_C_SER4;
      3: return `PIRL_C_PAR0;
      4: return `PIRL_C_TMR1;
      6: return `PIRL_C_AUDIO_LO;
      7: return `PIRL_C_PWM;
      8: return `PIRL_C_TMR2;
      9: return `PIRL_C_SPI_LO;
      default: return `PIRL_C_RESV_DEF;
    endcase
  endfunction : pirl_default

  // Reserved codes select nothing; the force code selects a constant one.
  function automatic logic pirl_pick(
    input pirl_code_t c,
    input logic [`PIRL_NSRC-1:0] r
  );
    if (c == `PIRL_C_FORCE) begin
      return 1'b1;
    end
    if (c <= `PIRL_C_LAST) begin
      return r[c];
    end
    return 1'b0;
  endfunction : pirl_pick

  function automatic logic pirl_is_resv(input pirl_code_t c);
    return (c > `PIRL_C_LAST) && (c != `PIRL_C_FORCE);
  endfunction : pirl_is_resv

  pirl_serdly #(
    .N(`PIRL_NSER),
    .DELAY(`PIRL_SER_DELAY)
  ) u_serdly (
    .clk(clk),
    .rst_n(rst_n),
    .word_done(ser_word_done),
    .irq(ser_irq)
  );

  pirl_ppirq u_ppirq (
    .clk(clk),
    .rst_n(rst_n),
    .pp(pp),
    .irq(parallel_port_irq)
  );

  // Request vector indexed by select code.
  always_comb begin
    reqs = '0;
    reqs[`PIRL_C_AUDIO_HI] = src.audio_if_high_irq;
    reqs[`PIRL_C_SPI_HI] = src.serial_periph_high_irq;
    reqs[`PIRL_C_TMR0] = src.gp_timer0_irq;
    reqs[`PIRL_C_SER1] = ser_irq[1];
    reqs[`PIRL_C_SER3] = ser_irq[3];
    reqs[`PIRL_C_SER5] = ser_irq[5];
    reqs[`PIRL_C_SER0] = ser_irq[0];
    reqs[`PIRL_C_SER2] = ser_irq[2];
    reqs[`PIRL_C_SER4] = ser_irq[4];
    reqs[`PIRL_C_PAR0] = parallel_port_irq;
    reqs[`PIRL_C_TMR1] = src.gp_timer1_irq;
    reqs[`PIRL_C_FUT_0B] = src.future_0b_irq;
    reqs[`PIRL_C_AUDIO_LO] = src.audio_if_low_irq;
    reqs[`PIRL_C_PWM] = src.pulse_width_irq;
    reqs[`PIRL_C_DPI] = src.dpi_irq;
    reqs[`PIRL_C_DTCP] = src.dtcp_irq;
    reqs[`PIRL_C_FUT_10] = src.future_10_irq;
    reqs[`PIRL_C_TMR2] = src.gp_timer2_irq;
    reqs[`PIRL_C_SPI_LO] = src.serial_periph_low_irq;
  end

  // Select codes, loaded one location at a time.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int k = 0; k < NLOC; k++) begin
        sel[k] <= pirl_default(k);
      end
    end else if (sel_wr && (sel_idx < 4'(NLOC))) begin
      sel[sel_idx] <= sel_code;
    end
  end

  always_comb begin
    for (int k = 0; k < NLOC; k++) begin
      hit[k] = LOC_VALID[k] && pirl_pick(sel[k], reqs);
    end
  end

  // A software write loads the latch bits and a sequencer acknowledge clears them; a new request
  // in the same cycle still wins, so no event is lost.
  always_comb begin
    next_lat = lat;
    if (sreg.wr) begin
      next_lat = sreg.wdata[`PIRL_LAT_LSB +: NLOC];
    end
    next_lat = next_lat & ~ack;
    next_lat = next_lat | hit;
    next_lat = next_lat & LOC_VALID;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lat <= '0;
    end else begin
      lat <= next_lat;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      msk <= '0;
    end else if (sreg.wr) begin
      msk <= sreg.wdata[`PIRL_MSK_LSB +: NLOC] & LOC_VALID;
    end
  end

  // The pointer copy ignores software writes; only the service events of
  // the sequencer move it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_pointer_bits <= '0;
    end else if (svc_enter) begin
      mask_pointer_bits <= msk & LOC_VALID;
    end else if (svc_exit) begin
      mask_pointer_bits <= '0;
    end
  end

  // The register drives the ext_interrupt_latch_mask port and is also read through the core system-register port.
  always_comb begin
    ext_interrupt_latch_mask = 32'h00000000;
    ext_interrupt_latch_mask[`PIRL_LAT_LSB +: NLOC] = lat;
    ext_interrupt_latch_mask[`PIRL_MSK_LSB +: NLOC] = msk;
    ext_interrupt_latch_mask[`PIRL_PTR_LSB +: NLOC] = mask_pointer_bits;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sreg_rdata <= `PIRL_EXT_RESET;
    end else if (sreg.rd) begin
      sreg_rdata <= ext_interrupt_latch_mask & `PIRL_EXT_VALID;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_pend <= '0;
    end else begin
      irq_pend <= lat & msk;
    end
  end

  logic [NLOC-1:0] resv_loc;

  always_comb begin
    for (int k = 0; k < NLOC; k++) begin
      resv_loc[k] = pirl_is_resv(sel[k]);
    end
  end

  sequence s_hit_quiet;
    (|(hit & msk)) && !sreg.wr ##1 !sreg.wr && (ack == '0);
  endsequence

  sequence s_force_held(int k);
    (sel[k] == `PIRL_C_FORCE) && !sreg.wr ##1 (sel[k] == `PIRL_C_FORCE);
  endsequence

  chk_reset_zero: assert property (
    @(posedge clk) !rst_n |=> (ext_interrupt_latch_mask == 32'h00000000)
  ) else $error("extended register not zero after reset");

  chk_route_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    (|hit) |=> ((lat & $past(hit)) == $past(hit))
  ) else $error("selected request did not set its latch bit");

  chk_rise_cause: assert property (
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> ((lat & ~$past(lat) & ~$past(hit) &
      ~($past(sreg.wdata[9:0]) & {NLOC{$past(sreg.wr)}})) == '0)
  ) else $error("latch bit rose without a selected request");

  chk_resv_code: assert property (
    @(posedge clk) disable iff (!rst_n)
    (|resv_loc) && !sreg.wr |=> ((lat & ~$past(lat) & $past(resv_loc)) == '0)
  ) else $error("reserved select code latched a request");

  chk_resv_bits: assert property (
    @(posedge clk) disable iff (!rst_n)
    (sreg_rdata & ~`PIRL_EXT_VALID) == 32'h00000000
      && !ext_interrupt_latch_mask[`PIRL_RESV_LOC]
  ) else $error("reserved bit reads as one");

  chk_force_high: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_force_held(4) |-> lat[4]
  ) else $error("forced location did not latch");

  chk_mask_pend: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_hit_quiet |=> (|irq_pend)
  ) else $error("unmasked latched request not pending");

  chk_mask_block: assert property (
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> ((irq_pend & ~$past(msk)) == '0)
  ) else $error("masked request reported pending");

  chk_ptr_guard: assert property (
    @(posedge clk) disable iff (!rst_n)
    sreg.wr && !svc_enter && !svc_exit |=> $stable(mask_pointer_bits)
  ) else $error("software write moved the mask pointer");

  chk_read_view: assert property (
    @(posedge clk) disable iff (!rst_n)
    sreg.rd |=> (sreg_rdata ==
      ($past(ext_interrupt_latch_mask) & `PIRL_EXT_VALID))
  ) else $error("read data does not match register state");

  // An acknowledge clears only where no new request lands in that cycle.
  chk_ack_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    (|(ack & ~hit)) && !sreg.wr |=> ((lat & $past(ack & ~hit)) == '0)
  ) else $error("acknowledged latch bit did not clear");

  chk_pend_follow: assert property (
    @(posedge clk) disable iff (!rst_n)
    (|(lat & msk)) |=> ((irq_pend & $past(lat & msk)) == $past(lat & msk))
  ) else $error("unmasked latched request not reported pending");

  // Service events and select loads are held against the ports behind them.
  chk_svc_copy: assert property (
    @(posedge clk) disable iff (!rst_n)
    svc_enter |=> (mask_pointer_bits == $past(msk))
  ) else $error("mask pointer did not copy the mask bits");

  chk_svc_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    svc_exit && !svc_enter |=> (mask_pointer_bits == '0)
  ) else $error("mask pointer not cleared at service exit");

  chk_sel_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    sel_wr && (sel_idx == 4'h4) |=> (sel[4] == $past(sel_code))
  ) else $error("select code not loaded into its location");

endmodule : pirl_top

// File: shared/pirl_defs.svh
`ifndef PIRL_DEFS_SVH
`define PIRL_DEFS_SVH

// Field layout of the extended latch, mask and mask pointer register.
`define PIRL_NLOC 10
`define PIRL_LAT_LSB 0
`define PIRL_MSK_LSB 10
`define PIRL_PTR_LSB 20
`define PIRL_RESV_LOC 5
`define PIRL_LOC_VALID 10'h3DF
`define PIRL_EXT_VALID 32'h3DFF7FDF
`define PIRL_EXT_RESET 32'h00000000

// Source select codes.
`define PIRL_NSRC 19
`define PIRL_C_AUDIO_HI 5'h00
`define PIRL_C_SPI_HI 5'h01
`define PIRL_C_TMR0 5'h02
`define PIRL_C_SER1 5'h03
`define PIRL_C_SER3 5'h04
`define PIRL_C_SER5 5'h05
`define PIRL_C_SER0 5'h06
`define PIRL_C_SER2 5'h07
`define PIRL_C_SER4 5'h08
`define PIRL_C_PAR0 5'h09
`define PIRL_C_TMR1 5'h0A
`define PIRL_C_FUT_0B 5'h0B
`define PIRL_C_AUDIO_LO 5'h0C
`define PIRL_C_PWM 5'h0D
`define PIRL_C_DPI 5'h0E
`define PIRL_C_DTCP 5'h0F
`define PIRL_C_FUT_10 5'h10
`define PIRL_C_TMR2 5'h11
`define PIRL_C_SPI_LO 5'h12
`define PIRL_C_LAST 5'h12
`define PIRL_C_FORCE 5'h1F
`define PIRL_C_RESV_DEF 5'h13

// Timing.
`define PIRL_NSER 6
`define PIRL_SER_DELAY 2

`endif

// File: shared/pirl_pkg.sv
`include "pirl_defs.svh"

package pirl_pkg;

  typedef logic [4:0] pirl_code_t;

  typedef struct packed {
    logic audio_if_high_irq;
    logic serial_periph_high_irq;
    logic gp_timer0_irq;
    logic gp_timer1_irq;
    logic future_0b_irq;
    logic audio_if_low_irq;
    logic pulse_width_irq;
    logic dpi_irq;
    logic dtcp_irq;
    logic future_10_irq;
    logic gp_timer2_irq;
    logic serial_periph_low_irq;
  } pirl_src_t;

  typedef struct packed {
    logic dma_done;
    logic core_mode;
    logic tx_full;
    logic rx_empty;
  } pirl_pp_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } pirl_sreg_t;

endpackage : pirl_pkg

// File: core/pirl_serdly.sv
`timescale 1ns/1ps
`include "pirl_defs.svh"

module pirl_serdly #(
  parameter int N = `PIRL_NSER,
  parameter int DELAY = `PIRL_SER_DELAY
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [N-1:0] word_done,
  output logic [N-1:0] irq
);
  import pirl_pkg::*;

  logic [DELAY-1:0][N-1:0] pipe;

  // A word end travels DELAY stages before it becomes a request.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pipe <= '0;
    end else begin
      pipe[0] <= word_done;
      for (int i = 1; i < DELAY; i++) begin
        pipe[i] <= pipe[i-1];
      end
    end
  end

  assign irq = pipe[DELAY-1];

  chk_ser_two_cycles: assert property (
    @(posedge clk) disable iff (!rst_n)
    (|word_done) |-> ##2 ((irq & $past(word_done, 2)) == $past(word_done, 2))
  ) else $error("serial request not raised two cycles after word end");

endmodule : pirl_serdly

// File: core/pirl_ppirq.sv
`timescale 1ns/1ps

module pirl_ppirq (
  input wire logic clk,
  input wire logic rst_n,
  input wire pirl_pkg::pirl_pp_t pp,
  output logic irq
);
  import pirl_pkg::*;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= pp.dma_done |
        (pp.core_mode & (~pp.tx_full | ~pp.rx_empty));
    end
  end

  chk_pp_dma_done: assert property (
    @(posedge clk) disable iff (!rst_n)
    pp.dma_done |=> irq
  ) else $error("parallel request missing after block transfer end");

  chk_pp_core_xfer: assert property (
    @(posedge clk) disable iff (!rst_n)
    (pp.core_mode && (!pp.tx_full || !pp.rx_empty)) |=> irq
  ) else $error("parallel request missing during core transfer");

  chk_pp_quiet: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!pp.dma_done && (!pp.core_mode || (pp.tx_full && pp.rx_empty)))
      |=> !irq
  ) else $error("parallel request raised without cause");

endmodule : pirl_ppirq

// File: verif/pirl_seq_model.sv
`timescale 1ns/1ps

module pirl_seq_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ack_en,
  input wire logic [9:0] irq_pend,
  output logic [9:0] ack
);
  // The sequencer acknowledges whatever it saw pending one cycle earlier.
  // A repeated acknowledge of a bit that is already clearing is harmless.
  always_ff @(posedge clk) begin
    if (!rst_n || !ack_en) begin
      ack <= 10'h000;
    end else begin
      ack <= irq_pend;
    end
  end
endmodule : pirl_seq_model

// File: verif/pirl_top_bench.sv
`timescale 1ns/1ps

module pirl_top_bench;
  import pirl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pirl_src_t src = '0;
  logic [5:0] swd = 6'h00;
  pirl_pp_t pp = '0;
  logic sel_wr = 1'b0;
  logic [3:0] sel_idx = 4'h0;
  pirl_code_t sel_code = 5'h00;
  pirl_sreg_t sreg = '0;
  logic [9:0] ack;
  logic svc_enter = 1'b0;
  logic svc_exit = 1'b0;
  logic ack_en = 1'b0;
  logic [31:0] rdata;
  logic [31:0] ext;
  logic [9:0] pend;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int sp[6] = '{1, 3, 5, 0, 2, 4};
  logic [4:0] dflt[10] = '{5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h13, 5'h0C,
    5'h0D, 5'h11, 5'h12};

  pirl_top dut (.clk(clk), .rst_n(rst_n), .src(src), .ser_word_done(swd),
    .pp(pp), .sel_wr(sel_wr), .sel_idx(sel_idx), .sel_code(sel_code),
    .sreg(sreg), .ack(ack), .svc_enter(svc_enter), .svc_exit(svc_exit),
    .sreg_rdata(rdata), .ext_interrupt_latch_mask(ext), .irq_pend(pend));

  pirl_seq_model seq (.clk(clk), .rst_n(rst_n), .ack_en(ack_en),
    .irq_pend(pend), .ack(ack));

  always #20 clk = ~clk;

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // The whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic sw(input logic [31:0] d);
    sreg = '{wr: 1'b1, rd: 1'b0, wdata: d};
    tick(1);
    sreg = '0;
  endtask : sw

  // Read data is registered and holds, so it is sampled a cycle late.
  task automatic sr(input logic [31:0] exp);
    sreg.rd = 1'b1;
    tick(1);
    sreg.rd = 1'b0;
    tick(1);
    chk("sreg_rdata", rdata, exp);
  endtask : sr

  task automatic sel(input logic [3:0] i, input logic [4:0] c);
    sel_wr = 1'b1;
    sel_idx = i;
    sel_code = c;
    tick(1);
    sel_wr = 1'b0;
  endtask : sel

  // Codes beyond the last source raise every source at once.
  task automatic fire(input logic [4:0] c);
    if (c > 5'h12) begin
      src = '1;
      swd = 6'h3F;
      pp.dma_done = 1'b1;
    end else if (c == 5'h09) begin
      pp.dma_done = 1'b1;
    end else if (c >= 5'h03 && c <= 5'h08) begin
      swd[sp[c-3]] = 1'b1;
    end else if (c <= 5'h02) begin
      src[11-c] = 1'b1;
    end else begin
      src[18-c] = 1'b1;
    end
    tick(1);
    src = '0;
    swd = 6'h00;
    pp.dma_done = 1'b0;
  endtask : fire

  initial begin
    int lat;
    tick(2);
    rst_n = 1'b1;
    chk("ext reset", ext, 32'h00000000);
    sr(32'h00000000);
    sw(32'h000FFFFF);
    chk("ext all ones", ext, 32'h000F7FDF);
    tick(1);
    sr(32'h000F7FDF);
    sw(32'h00000000);
    chk("ext cleared", ext, 32'h00000000);
    $display("test register done");
    for (int i = 0; i < 10; i++) begin
      lat = (i < 3) ? 3 : ((i == 3) ? 2 : 1);
      fire(dflt[i]);
      for (int j = 1; j <= lat; j++) begin
        if (j > 1) tick(1);
        chk("dflt latch", {31'h0, ext[i]}, 32'(j == lat && i != 5));
      end
      tick(1);
      sw(32'h00000000);
    end
    $display("test defaults done");
    for (int c = 0; c < 32; c++) begin
      sel(4'h4, c[4:0]);
      fire(c[4:0]);
      tick(3);
      chk("routed latch", {31'h0, ext[4]}, 32'(c <= 18 || c == 31));
      sw(32'h00000000);
    end
    sel(4'h4, 5'h0A);
    sw(32'h00000000);
    $display("test codes done");
    fire(5'h0A);
    tick(2);
    chk("masked pend", {22'h0, pend}, 32'h00000000);
    sw(32'h00004010);
    tick(1);
    chk("unmasked pend", {22'h0, pend}, 32'h00000010);
    ack_en = 1'b1;
    tick(4);
    chk("acked latch", ext, 32'h00004000);
    ack_en = 1'b0;
    pp.core_mode = 1'b1;
    pp.rx_empty = 1'b1;
    pp.tx_full = 1'b1;
    tick(3);
    chk("core mode idle", {31'h0, ext[3]}, 32'h00000000);
    pp.tx_full = 1'b0;
    tick(2);
    chk("core mode tx", {31'h0, ext[3]}, 32'h00000001);
    pp = '0;
    $display("test pend done");
    sw(32'h000F7C00);
    svc_enter = 1'b1;
    tick(1);
    svc_enter = 1'b0;
    chk("pointer copy", {22'h0, ext[29:20]}, 32'h000003DF);
    sw(32'h3DFF7C00);
    chk("pointer kept", {22'h0, ext[29:20]}, 32'h000003DF);
    svc_exit = 1'b1;
    tick(1);
    svc_exit = 1'b0;
    chk("pointer clear", {22'h0, ext[29:20]}, 32'h00000000);
    $display("test service done");
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    chk("ext after reset", ext, 32'h00000000);
    chk("rdata after reset", rdata, 32'h00000000);
    fire(5'h0A);
    chk("default restored", {31'h0, ext[4]}, 32'h00000001);
    $display("test reset done");
    wrap_up();
  end
endmodule : pirl_top_bench
